/* design/gsa_gate_ctrl.sv */
// gate-controlled acquisition control: gate detection, start delay, end alignment, storing
`timescale 1ns/1ns
`include "gsa_consts.svh"
module gsa_gate_ctrl (
	input  wire logic          sys_clk,
	input  wire logic          rst,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	input  wire logic [31:0]   reg_index,
	input  wire logic [31:0]   reg_wdata,
	output logic      [31:0]   reg_rdata,
	output logic               reg_rack,
	input  wire logic          ext_trig,
	input  wire logic          smp_valid,
	input  wire logic [15:0]   smp_data,
	output logic               smp_ready,
	output logic               out_valid,
	output logic      [15:0]   out_data,
	output logic      [31:0]   out_addr,
	output logic               out_block_end,
	input  wire logic          out_ready,
	output gsa_pkg::gsa_state_t acq_state
);
	import gsa_pkg::*;

	localparam int PIPE = `GSA_PIPE_DEPTH;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [2:0] chan_words(input logic [1:0] sel);
		unique case (gsa_chsel_t'(sel))
			GSA_CH0:          chan_words = 3'h1;
			GSA_CH01, GSA_CH02: chan_words = 3'h2;
			GSA_CH0123:       chan_words = 3'h4;
		endcase
	endfunction

	function automatic logic [4:0] shortfall(input logic [1:0] sel, input logic hi);
		unique case (gsa_chsel_t'(sel))
			GSA_CH0:            shortfall = hi ? `GSA_LESS_1_HI : `GSA_LESS_1_LO;
			GSA_CH01, GSA_CH02: shortfall = hi ? `GSA_LESS_2_HI : `GSA_LESS_2_LO;
			GSA_CH0123:         shortfall = hi ? `GSA_LESS_4_HI : `GSA_LESS_4_LO;
		endcase
	endfunction

	function automatic logic is_long(input logic [3:0] m);
		is_long = (m == GSA_EXT_LONG_HIGH_GATE) || (m == GSA_EXT_LONG_LOW_GATE)
			|| (m == GSA_CHAN_LONG_ABOVE_GATE) || (m == GSA_CHAN_LONG_BELOW_GATE)
			|| (m == GSA_CHAN_LONG_WIN_IN) || (m == GSA_CHAN_LONG_WIN_OUT);
	endfunction

	// ************************************************************
	// external gate pin synchroniser
	// ************************************************************
	logic ext_meta;
	logic ext_sync;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
		end else begin
			ext_meta <= ext_trig;
			ext_sync <= ext_meta;
		end
	end

	// ************************************************************
	// parameter registers
	// ************************************************************
	logic        [31:0] total_sample_count;
	logic               gated_sampling_enable;
	logic        [3:0]  trigger_mode_select;
	logic        [1:0]  chan_sel;
	logic               fifo_mode;
	logic               rate_high;
	logic signed [15:0] level_hi;
	logic signed [15:0] level_lo;
	logic        [15:0] pulse_width;
	logic        [31:0] next_total_sample_count;
	logic               next_gated_sampling_enable;
	logic        [3:0]  next_trigger_mode_select;
	logic        [1:0]  next_chan_sel;
	logic               next_fifo_mode;
	logic               next_rate_high;
	logic signed [15:0] next_level_hi;
	logic signed [15:0] next_level_lo;
	logic        [15:0] next_pulse_width;
	logic        [31:0] next_reg_rdata;
	logic               start_cmd;
	logic               stop_cmd;
	logic               mode_bad;
	logic               cond;
	logic        [31:0] stored;

	always_comb begin
		next_total_sample_count    = total_sample_count;
		next_gated_sampling_enable = gated_sampling_enable;
		next_trigger_mode_select   = trigger_mode_select;
		next_chan_sel              = chan_sel;
		next_fifo_mode             = fifo_mode;
		next_rate_high             = rate_high;
		next_level_hi              = level_hi;
		next_level_lo              = level_lo;
		next_pulse_width           = pulse_width;
		start_cmd                  = 1'b0;
		stop_cmd                   = 1'b0;
		next_reg_rdata             = 32'h0000_0000;
		if (reg_wr) begin
			case (reg_index)
				`GSA_IDX_TOTAL:     next_total_sample_count = reg_wdata;
				`GSA_IDX_GATE_EN:   next_gated_sampling_enable = reg_wdata[0];
				`GSA_IDX_TRIG_MODE: next_trigger_mode_select = reg_wdata[3:0];
				`GSA_IDX_CHAN_SEL:  next_chan_sel = reg_wdata[1:0];
				`GSA_IDX_LEVEL_HI:  next_level_hi = reg_wdata[15:0];
				`GSA_IDX_LEVEL_LO:  next_level_lo = reg_wdata[15:0];
				`GSA_IDX_PULSE_W:   next_pulse_width = reg_wdata[15:0];
				`GSA_IDX_CTRL: begin
					next_fifo_mode = reg_wdata[`GSA_CTRL_FIFO];
					next_rate_high = reg_wdata[`GSA_CTRL_RATE_HIGH];
					start_cmd      = reg_wdata[`GSA_CTRL_START];
					stop_cmd       = reg_wdata[`GSA_CTRL_STOP];
				end
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_index)
				`GSA_IDX_TOTAL:     next_reg_rdata = total_sample_count;
				`GSA_IDX_GATE_EN:   next_reg_rdata = {31'h0, gated_sampling_enable};
				`GSA_IDX_TRIG_MODE: next_reg_rdata = {28'h0, trigger_mode_select};
				`GSA_IDX_CHAN_SEL:  next_reg_rdata = {30'h0, chan_sel};
				`GSA_IDX_LEVEL_HI:  next_reg_rdata = {16'h0, level_hi};
				`GSA_IDX_LEVEL_LO:  next_reg_rdata = {16'h0, level_lo};
				`GSA_IDX_PULSE_W:   next_reg_rdata = {16'h0, pulse_width};
				`GSA_IDX_CTRL:      next_reg_rdata = {28'h0, rate_high, fifo_mode, 2'h0};
				`GSA_IDX_STATUS:    next_reg_rdata = {27'h0, cond, mode_bad, acq_state};
				`GSA_IDX_STORED:    next_reg_rdata = stored;
				default:            next_reg_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			total_sample_count    <= `GSA_RST_TOTAL;
			gated_sampling_enable <= 1'b0;
			trigger_mode_select   <= 4'h0;
			chan_sel              <= 2'h0;
			fifo_mode             <= 1'b0;
			rate_high             <= 1'b0;
			level_hi              <= `GSA_RST_LEVEL_HI;
			level_lo              <= `GSA_RST_LEVEL_LO;
			pulse_width           <= `GSA_RST_PULSE_W;
			reg_rdata             <= 32'h0000_0000;
			reg_rack              <= 1'b0;
		end else begin
			total_sample_count    <= next_total_sample_count;
			gated_sampling_enable <= next_gated_sampling_enable;
			trigger_mode_select   <= next_trigger_mode_select;
			chan_sel              <= next_chan_sel;
			fifo_mode             <= next_fifo_mode;
			rate_high             <= next_rate_high;
			level_hi              <= next_level_hi;
			level_lo              <= next_level_lo;
			pulse_width           <= next_pulse_width;
			reg_rdata             <= next_reg_rdata;
			reg_rack              <= reg_rd;
		end
	end

	// ************************************************************
	// gate condition
	// ************************************************************
	logic [2:0]  slot;
	logic        accept;
	logic        eval;
	logic        above;
	logic        inwin;
	logic        cond_prev;
	logic [15:0] pw_cnt;
	logic        start_hit;
	logic        gate_cond;
	logic        next_cond_prev;
	logic [15:0] next_pw_cnt;

	always_comb begin
		accept   = smp_valid & smp_ready;
		eval     = accept && (slot == 3'h0);
		above    = $signed(smp_data) > level_hi;
		inwin    = ($signed(smp_data) <= level_hi) && ($signed(smp_data) >= level_lo);
		mode_bad = 1'b0;
		case (trigger_mode_select)
			GSA_EXT_RISING_GATE, GSA_EXT_LONG_HIGH_GATE:     cond = ext_sync;
			GSA_EXT_FALLING_GATE, GSA_EXT_LONG_LOW_GATE:     cond = ~ext_sync;
			GSA_CHAN_UP_CROSS_GATE, GSA_CHAN_LONG_ABOVE_GATE: cond = above;
			GSA_CHAN_DOWN_CROSS_GATE, GSA_CHAN_LONG_BELOW_GATE: cond = ~above;
			GSA_CHAN_WIN_IN_GATE, GSA_CHAN_LONG_WIN_IN:      cond = inwin;
			GSA_CHAN_WIN_OUT_GATE, GSA_CHAN_LONG_WIN_OUT:    cond = ~inwin;
			default: begin
				cond     = 1'b0;
				mode_bad = 1'b1;
			end
		endcase
		// edge modes need a fresh transition, pulse modes a held level
		start_hit = !gated_sampling_enable || (is_long(trigger_mode_select)
			? (cond && (pw_cnt > pulse_width)) : (cond && !cond_prev));
		gate_cond = !gated_sampling_enable || cond;
		next_cond_prev = cond_prev;
		next_pw_cnt    = pw_cnt;
		if (start_cmd) begin
			next_cond_prev = 1'b1;
			next_pw_cnt    = 16'h0000;
		end else if (eval) begin
			next_cond_prev = cond;
			if (!cond) begin
				next_pw_cnt = 16'h0000;
			end else if (pw_cnt != 16'hFFFF) begin
				next_pw_cnt = pw_cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cond_prev <= 1'b1;
			pw_cnt    <= 16'h0000;
		end else begin
			cond_prev <= next_cond_prev;
			pw_cnt    <= next_pw_cnt;
		end
	end

	// ************************************************************
	// acquisition sequencer
	// ************************************************************
	logic [15:0] hist [0:PIPE-1];
	logic [15:0] next_hist [0:PIPE-1];
	gsa_state_t  next_state;
	logic [31:0] next_stored;
	logic [7:0]  skip_cnt;
	logic [7:0]  next_skip;
	logic [2:0]  next_slot;
	logic        store_now;
	logic        limit_hit;
	logic        blk_end;

	always_comb begin
		next_state  = acq_state;
		next_stored = stored;
		next_skip   = skip_cnt;
		next_slot   = slot;
		store_now   = 1'b0;
		// the stored word trails the live one, so the trigger itself can land in memory
		for (int i = 0; i < PIPE; i++) begin
			next_hist[i] = hist[i];
		end
		if (accept) begin
			next_hist[0] = smp_data;
			for (int i = 1; i < PIPE; i++) begin
				next_hist[i] = hist[i-1];
			end
			next_slot = (slot == chan_words(chan_sel) - 3'h1) ? 3'h0 : slot + 3'h1;
		end
		limit_hit = !fifo_mode && (stored + 32'h1 == total_sample_count);
		unique case (acq_state)
			GSA_IDLE, GSA_DONE: ;
			GSA_ARMED: begin
				if (eval && start_hit) begin
					// fixed loss per setup, the trigger word counts as the first
					next_state = GSA_SKIP;
					next_skip  = 8'(shortfall(chan_sel, rate_high) * chan_words(chan_sel)) - 8'h1;
				end
			end
			GSA_SKIP: begin
				if (eval && !gate_cond) begin
					next_state = GSA_ARMED;
				end else if (accept) begin
					if (skip_cnt == 8'h1) begin
						next_state = GSA_REC;
					end else begin
						next_skip = skip_cnt - 8'h1;
					end
				end
			end
			GSA_REC: begin
				if (eval && !gate_cond && (stored[2:0] == 3'h0)) begin
					next_state = GSA_ARMED;
				end else if (accept) begin
					store_now   = 1'b1;
					next_stored = stored + 32'h1;
					if (limit_hit) begin
						next_state = GSA_DONE;
					end else if (eval && !gate_cond) begin
						next_state = ((next_stored[2:0] & `GSA_ALIGN_MASK) == 3'h0)
							? GSA_ARMED : GSA_ALIGN;
					end
				end
			end
			GSA_ALIGN: begin
				if (accept) begin
					// boundary counts words of all channels: 8, 4 or 2 per channel
					store_now   = 1'b1;
					next_stored = stored + 32'h1;
					if (limit_hit) begin
						next_state = GSA_DONE;
					end else if ((next_stored[2:0] & `GSA_ALIGN_MASK) == 3'h0) begin
						next_state = GSA_ARMED;
					end
				end
			end
		endcase
		if (start_cmd && (acq_state == GSA_IDLE || acq_state == GSA_DONE)) begin
			next_state  = GSA_ARMED;
			next_stored = 32'h0;
			next_slot   = 3'h0;
		end
		if (stop_cmd) begin
			next_state = GSA_IDLE;
		end
		blk_end = fifo_mode && ((stored & `GSA_BLOCK_MASK) == `GSA_BLOCK_MASK);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			acq_state <= GSA_IDLE;
			stored    <= 32'h0;
			skip_cnt  <= 8'h0;
			slot      <= 3'h0;
			for (int i = 0; i < PIPE; i++) begin
				hist[i] <= 16'h0000;
			end
		end else begin
			acq_state <= next_state;
			stored    <= next_stored;
			skip_cnt  <= next_skip;
			slot      <= next_slot;
			for (int i = 0; i < PIPE; i++) begin
				hist[i] <= next_hist[i];
			end
		end
	end

	// ************************************************************
	// output buffer; a stall stops sample intake, nothing is lost
	// ************************************************************
	gsa_skid #(.WIDTH(49)) u_skid (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_valid  (store_now),
		.in_data   ({blk_end, stored, hist[PIPE-1]}),
		.in_ready  (smp_ready),
		.out_valid (out_valid),
		.out_data  ({out_block_end, out_addr, out_data}),
		.out_ready (out_ready)
	);

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_gate_open;
		acq_state == GSA_ARMED && eval && start_hit && !stop_cmd;
	endsequence

	property p_store_in_gate;
		@(posedge sys_clk) disable iff (rst)
		store_now |-> (acq_state == GSA_REC || acq_state == GSA_ALIGN);
	endproperty
	a_store_in_gate: assert property (p_store_in_gate)
		else $error("word stored outside a gate interval");

	property p_total_halt;
		@(posedge sys_clk) disable iff (rst)
		(acq_state == GSA_REC || acq_state == GSA_ALIGN) && !fifo_mode
			|-> stored != total_sample_count;
	endproperty
	a_total_halt: assert property (p_total_halt)
		else $error("recording past the programmed total");

	property p_fifo_no_done;
		@(posedge sys_clk) disable iff (rst)
		(acq_state != GSA_DONE && fifo_mode) |=> acq_state != GSA_DONE;
	endproperty
	a_fifo_no_done: assert property (p_fifo_no_done)
		else $error("fifo mode halted on a count");

	property p_align_end;
		@(posedge sys_clk) disable iff (rst)
		(acq_state == GSA_ARMED && $past(acq_state) == GSA_ALIGN) |-> stored[2:0] == 3'h0;
	endproperty
	a_align_end: assert property (p_align_end)
		else $error("pause entered off the eight-word boundary");

	property p_skip_len;
		@(posedge sys_clk) disable iff (rst)
		s_gate_open |=> (acq_state == GSA_SKIP)
			&& (skip_cnt == 8'(shortfall(chan_sel, rate_high) * chan_words(chan_sel)) - 8'h1);
	endproperty
	a_skip_len: assert property (p_skip_len)
		else $error("start delay loaded with the wrong count");

	property p_bad_mode;
		@(posedge sys_clk) disable iff (rst)
		(acq_state == GSA_ARMED && mode_bad && gated_sampling_enable && !start_cmd)
			|=> acq_state inside {GSA_ARMED, GSA_IDLE};
	endproperty
	a_bad_mode: assert property (p_bad_mode)
		else $error("unlisted trigger mode opened the gate");

	property p_pause_hold;
		@(posedge sys_clk) disable iff (rst)
		(acq_state == GSA_ARMED && !start_cmd) |=> stored == $past(stored);
	endproperty
	a_pause_hold: assert property (p_pause_hold)
		else $error("write position moved during a pause");

	property p_long_pulse;
		@(posedge sys_clk) disable iff (rst)
		(s_gate_open and (gated_sampling_enable && is_long(trigger_mode_select)))
			|-> $past(pw_cnt) >= pulse_width;
	endproperty
	a_long_pulse: assert property (p_long_pulse)
		else $error("pulse gate opened before the width elapsed");

endmodule

/* design/gsa_consts.svh */
// register indices, field positions, reset values and counts for the gated acquisition control
// What this block does
// - store only while the gate condition holds
// - standard mode halts at programmed total immediately
// - no pre-trigger, no post-trigger count when gated
// - gated operation enabled by read/write parameter
// - standard mode total comes from total register
// - fifo mode runs until stopped, handed blockwise
// - gate end only on eight-word boundary
// - alignment is 8, 4 or 2 per channel
// - start delay fixed per setup
// - one channel loses 7 or 12 samples
// - two channels 3 or 6, four 2 or 3
// - pipeline lets the data delay go negative
// - only listed trigger modes may open the gate
// - external edge modes open and close the gate
// - external pulse modes need a long pulse first
// - channel level crossings open and close the gate
// - channel pulse modes need long level first
// - window enter or leave opens, opposite closes
// - window pulse modes need long transition first
`ifndef GSA_CONSTS_SVH
`define GSA_CONSTS_SVH

// ************************************************************
// parameter indices
// ************************************************************
`define GSA_IDX_TOTAL      32'h0000_2710
`define GSA_IDX_GATE_EN    32'h0003_5CF0
`define GSA_IDX_CTRL       32'h0000_0100
`define GSA_IDX_CHAN_SEL   32'h0000_0101
`define GSA_IDX_LEVEL_HI   32'h0000_0102
`define GSA_IDX_LEVEL_LO   32'h0000_0103
`define GSA_IDX_PULSE_W    32'h0000_0104
`define GSA_IDX_TRIG_MODE  32'h0000_0105
`define GSA_IDX_STATUS     32'h0000_0106
`define GSA_IDX_STORED     32'h0000_0107

// ************************************************************
// field positions
// ************************************************************
`define GSA_CTRL_START     0
`define GSA_CTRL_STOP      1
`define GSA_CTRL_FIFO      2
`define GSA_CTRL_RATE_HIGH 3
`define GSA_STS_MODE_BAD   3
`define GSA_STS_COND       4

// ************************************************************
// reset values
// ************************************************************
`define GSA_RST_TOTAL      32'h0000_1000
`define GSA_RST_LEVEL_HI   16'h0000
`define GSA_RST_LEVEL_LO   16'h0000
`define GSA_RST_PULSE_W    16'h0010

// ************************************************************
// counts
// ************************************************************
`define GSA_ALIGN_MASK     3'h7
`define GSA_LESS_1_LO      5'h07
`define GSA_LESS_1_HI      5'h0C
`define GSA_LESS_2_LO      5'h03
`define GSA_LESS_2_HI      5'h06
`define GSA_LESS_4_LO      5'h02
`define GSA_LESS_4_HI      5'h03
`define GSA_PIPE_DEPTH     8
`define GSA_BLOCK_MASK     32'h0000_0FFF

`endif

/* design/gsa_pkg.sv */
// types shared by the gated acquisition control
package gsa_pkg;

	typedef enum logic [2:0] {
		GSA_IDLE  = 3'h0,
		GSA_ARMED = 3'h1,
		GSA_SKIP  = 3'h2,
		GSA_REC   = 3'h3,
		GSA_ALIGN = 3'h4,
		GSA_DONE  = 3'h5
	} gsa_state_t;

	typedef enum logic [3:0] {
		GSA_EXT_RISING_GATE      = 4'h0,
		GSA_EXT_FALLING_GATE     = 4'h1,
		GSA_EXT_LONG_HIGH_GATE   = 4'h2,
		GSA_EXT_LONG_LOW_GATE    = 4'h3,
		GSA_CHAN_UP_CROSS_GATE   = 4'h4,
		GSA_CHAN_DOWN_CROSS_GATE = 4'h5,
		GSA_CHAN_LONG_ABOVE_GATE = 4'h6,
		GSA_CHAN_LONG_BELOW_GATE = 4'h7,
		GSA_CHAN_WIN_IN_GATE     = 4'h8,
		GSA_CHAN_LONG_WIN_IN     = 4'h9,
		GSA_CHAN_WIN_OUT_GATE    = 4'hA,
		GSA_CHAN_LONG_WIN_OUT    = 4'hB
	} gsa_mode_t;

	typedef enum logic [1:0] {
		GSA_CH0    = 2'h0,
		GSA_CH01   = 2'h1,
		GSA_CH02   = 2'h2,
		GSA_CH0123 = 2'h3
	} gsa_chsel_t;

endpackage

/* design/gsa_skid.sv */
// two-entry skid buffer between the acquisition control and the memory writer
`timescale 1ns/1ns
module gsa_skid #(
	parameter int WIDTH = 49
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);

	logic             skid_valid;
	logic [WIDTH-1:0] skid_data;
	logic             next_skid_valid;
	logic [WIDTH-1:0] next_skid_data;
	logic             next_out_valid;
	logic [WIDTH-1:0] next_out_data;
	logic             accept;

	// ************************************************************
	// next values
	// ************************************************************
	// ready is registered, so the second entry catches the word in flight
	always_comb begin
		accept          = in_valid & in_ready;
		next_skid_valid = skid_valid;
		next_skid_data  = skid_data;
		next_out_valid  = out_valid;
		next_out_data   = out_data;
		if (!out_valid || out_ready) begin
			if (skid_valid) begin
				next_out_valid  = 1'b1;
				next_out_data   = skid_data;
				next_skid_valid = 1'b0;
			end else begin
				next_out_valid = accept;
				if (accept) begin
					next_out_data = in_data;
				end
			end
		end else if (accept) begin
			next_skid_valid = 1'b1;
			next_skid_data  = in_data;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			skid_valid <= 1'b0;
			skid_data  <= '0;
			out_valid  <= 1'b0;
			out_data   <= '0;
			in_ready   <= 1'b0;
		end else begin
			skid_valid <= next_skid_valid;
			skid_data  <= next_skid_data;
			out_valid  <= next_out_valid;
			out_data   <= next_out_data;
			in_ready   <= ~next_skid_valid;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	property p_stall_holds;
		@(posedge sys_clk) disable iff (rst)
		(out_valid && !out_ready) |=> (out_valid && out_data == $past(out_data));
	endproperty
	a_stall_holds: assert property (p_stall_holds)
		else $error("stalled output word changed");

	property p_no_overrun;
		@(posedge sys_clk) disable iff (rst)
		(skid_valid && out_valid && !out_ready) |-> !in_ready;
	endproperty
	a_no_overrun: assert property (p_no_overrun)
		else $error("buffer accepts while both entries full");

endmodule

/* tb/gsa_gate_src.sv */
// sample word source and external gate driver facing the acquisition control
`timescale 1ns/1ns
module gsa_gate_src (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        gate_level,
	input  wire logic        smp_ready,
	output logic             ext_trig,
	output logic             smp_valid,
	output logic      [15:0] smp_data
);
	logic acc;
	logic lvl;
	// ****************************************
	// word stream and gate pin
	// ****************************************
	// a word stays put until taken, so a stall never loses a sample
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			smp_valid <= 1'b0;
			smp_data  <= 16'h0000;
			ext_trig  <= 1'b0;
		end else begin
			acc = smp_valid & smp_ready;
			lvl = gate_level;
			#2;
			smp_valid <= 1'b1;
			if (acc) begin
				smp_data <= smp_data + 16'h0001;
			end
			ext_trig <= lvl;
		end
	end
endmodule

/* tb/gsa_gate_ctrl_bench.sv */
// self-checking bench for the gated acquisition control
`timescale 1ns/1ns
`include "gsa_consts.svh"
module gsa_gate_ctrl_bench;
	import gsa_pkg::*;
	logic        sys_clk, rst, reg_wr, reg_rd, reg_rack, ext_trig, gate;
	logic        smp_valid, smp_ready, out_valid, out_block_end, out_ready;
	logic [31:0] reg_index, reg_wdata, reg_rdata, out_addr, addr_base, want;
	logic [31:0] exp_addr = 32'h0;
	logic [15:0] smp_data, out_data;
	logic [15:0] last_data = 16'h0;
	logic        fifo_on, blk_exp;
	gsa_state_t  acq_state;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int          errors, n_tests;
	int          seed = 32'h15d21740;

	gsa_gate_ctrl dut_u (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_index, .reg_wdata,
		.reg_rdata, .reg_rack, .ext_trig, .smp_valid, .smp_data, .smp_ready, .out_valid,
		.out_data, .out_addr, .out_block_end, .out_ready, .acq_state);
	gsa_gate_src src_u (.sys_clk, .rst, .gate_level(gate), .smp_ready, .ext_trig,
		.smp_valid, .smp_data);

	// ****************************************
	// report and compare
	// ****************************************
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic fail(input string m);
		errors++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic chk_reg(input logic [31:0] got, exp, msk);
		n_tests++;
		if (((got ^ exp) & msk) !== 32'h0) fail("read data mismatch");
	endtask
	task automatic chk_addr(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) fail("write position gap");
	endtask
	task automatic chk_blk(input logic got, exp);
		n_tests++;
		if (got !== exp) fail("block end flag mismatch");
	endtask
	task automatic chk_data(input logic [15:0] got, exp);
		n_tests++;
		if (got !== exp) fail("stored word not contiguous");
	endtask

	// ****************************************
	// drivers
	// ****************************************
	task automatic wr(input logic [31:0] i, d);
		@(posedge sys_clk) #2;
		reg_wr = 1'b1;
		reg_index = i;
		reg_wdata = d;
		@(posedge sys_clk) #2;
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [31:0] i, e, m);
		@(posedge sys_clk) #2;
		reg_rd = 1'b1;
		reg_index = i;
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge sys_clk) #2;
		reg_rd = 1'b0;
	endtask
	task automatic wait_st(input gsa_state_t s);
		for (int k = 0; k < 2000; k++) begin
			@(posedge sys_clk);
			if (acq_state === s) return;
		end
		fail("state wait ran out");
		wrap_up();
	endtask
	task automatic pulse(input int n);
		@(posedge sys_clk) #2;
		gate = 1'b1;
		repeat (n) @(posedge sys_clk);
		#2 gate = 1'b0;
	endtask

	// ****************************************
	// clock, stall and monitor
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// random stalls keep the two-entry buffer busy
	always @(posedge sys_clk) #2 out_ready = ($random(seed) % 4) != 0;
	always @(posedge sys_clk) begin
		if (reg_rack === 1'b1) begin
			if (exp_q.size() == 0) fail("unexpected read answer");
			else chk_reg(reg_rdata, exp_q.pop_front(), msk_q.pop_front());
		end
		if (out_valid === 1'b1 && out_ready === 1'b1) begin
			want = exp_addr - addr_base;
			blk_exp = fifo_on && ((want & `GSA_BLOCK_MASK) == `GSA_BLOCK_MASK);
			chk_addr(out_addr, want);
			chk_blk(out_block_end, blk_exp);
			// pauses only start on an eight-word boundary, so inside one the source count runs on
			if (want[2:0] != 3'h0) chk_data(out_data, last_data + 16'h1);
			last_data = out_data;
			exp_addr = exp_addr + 32'h1;
		end
	end
	initial begin
		#3000000;
		fail("run too long");
		wrap_up();
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, gate, fifo_on} = 4'h0;
		{reg_index, reg_wdata, addr_base} = 96'h0;
		errors = 0;
		n_tests = 0;
		repeat (12) @(posedge sys_clk);
		#2 rst = 1'b0;
		repeat (2) @(posedge sys_clk);
		rd(`GSA_IDX_TOTAL, `GSA_RST_TOTAL, '1);
		rd(`GSA_IDX_GATE_EN, 32'h0, '1);
		rd(32'h0000_0200, 32'h0, '1);
		wr(`GSA_IDX_TOTAL, 32'h0000_A5C3);
		wr(`GSA_IDX_GATE_EN, 32'h1);
		rd(`GSA_IDX_TOTAL, 32'h0000_A5C3, '1);
		rd(`GSA_IDX_GATE_EN, 32'h1, 32'h1);
		$display("test registers done");
		wr(`GSA_IDX_TRIG_MODE, 32'h0);
		wr(`GSA_IDX_CTRL, 32'h1);
		wait_st(GSA_ARMED);
		// two gates: store stops on eight-word boundary and resumes contiguously
		for (int g = 0; g < 2; g++) begin
			pulse(50 - 20 * g);
			wait_st(GSA_ARMED);
			rd(`GSA_IDX_STORED, 32'h0, 32'h7);
		end
		chk_reg({31'h0, exp_addr > 32'h8}, 32'h1, '1);
		$display("test gated run done");
		wr(`GSA_IDX_CTRL, 32'h2);
		wr(`GSA_IDX_TOTAL, 32'h10);
		repeat (10) @(posedge sys_clk);
		#2 addr_base = exp_addr;
		wr(`GSA_IDX_CTRL, 32'h1);
		wait_st(GSA_ARMED);
		pulse(100);
		wait_st(GSA_DONE);
		rd(`GSA_IDX_STORED, 32'h10, '1);
		$display("test total halt done");
		wr(`GSA_IDX_CTRL, 32'h2);
		wr(`GSA_IDX_TRIG_MODE, 32'hC);
		wr(`GSA_IDX_CTRL, 32'h1);
		wait_st(GSA_ARMED);
		pulse(20);
		rd(`GSA_IDX_STATUS, 32'h9, 32'hF);
		$display("test illegal mode done");
		wr(`GSA_IDX_CTRL, 32'h2);
		wr(`GSA_IDX_TRIG_MODE, 32'h0);
		wr(`GSA_IDX_CHAN_SEL, 32'h3);
		addr_base = exp_addr;
		fifo_on = 1'b1;
		// four channels at the high rate, streaming past one whole block
		wr(`GSA_IDX_CTRL, 32'hD);
		wait_st(GSA_ARMED);
		pulse(6000);
		wait_st(GSA_ARMED);
		rd(`GSA_IDX_STORED, 32'h0, 32'h7);
		repeat (4) @(posedge sys_clk);
		chk_reg({31'h0, exp_addr - addr_base > 32'h1000}, 32'h1, '1);
		$display("test fifo run done");
		repeat (4) @(posedge sys_clk);
		wrap_up();
	end
endmodule
